// *** sxc_pkg.sv ***
// Package for the exception and low-power controller.
// Assumes a single core clock domain; crystal clock counts are in core cycles.
package sxc_pkg;
  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [3:0] ADDR_BREAK_STATUS = 4'h0;
  localparam logic [3:0] ADDR_BREAK_FLAG_CTRL = 4'h1;
  localparam logic [3:0] ADDR_CONFIG = 4'h2;
  localparam logic [3:0] ADDR_STATE = 4'h3;
  localparam logic [3:0] ADDR_LATCHED = 4'h4;
  localparam int BW_BIT = 1;
  localparam int BREAK_CLEAR_ENABLE_BIT = 7;
  localparam int CFG_SHORT_STOP_RECOVERY_BIT = 0;
  localparam int CFG_STOPEN_BIT = 1;
  localparam int CFG_WDDIS_BIT = 2;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] BFCR_RST = 8'h00;
  // ==========================================================
  // Timing
  // ==========================================================
  localparam int LONG_RECOVERY_CYC = 4096;
  localparam int SHORT_RECOVERY_CYC = 32;
  localparam int CNT_W = 13;
  // ==========================================================
  // Vectors and states
  // ==========================================================
  localparam logic [7:0] VEC_SWI = 8'hFF;
  localparam logic [7:0] VEC_RESET = 8'hFE;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_STACK = 3'b001,
    ST_WAIT = 3'b010,
    ST_STOP = 3'b011,
    ST_RECOVER = 3'b100,
    ST_RESET = 3'b101
  } sxc_state_t;
endpackage

// *** sxc_ctrl.sv ***
// Exception, break and low-power sequencing for the CPU core.
// Assumes CPU strobes and interrupt lines are synchronous to I_CLK;
// break and reset-source inputs are also core-clocked pulses or levels.
//
// Functional notes
// - Entry stacks registers, sets mask; return restores.
// - Latch and arbitrate requests; result selects vector.
// - Latched request holds until serviced or unmasked.
// - Check requests at instruction completion, or every cycle in wait and stop.
// - Highest priority pending request wins.
// - Pending request serviced straight after return.
// - High index register is never stacked.
// - Software interrupt ignores global mask.
// - Software stacks PC, hardware stacks PC-1.
// - Resets override all interrupts, no arbitration.
// - Break forces software interrupt vector.
// - Flags protected in break unless clear enabled.
// - Flag cleared during break stays cleared.
// - Two-step clears stay protected across break.
// - Wait/stop stop CPU clock, clear mask.
// - Wait keeps peripheral clocks; interrupt wakes.
// - Reset or break ends wait; break sets flag.
// - Watchdog runs in wait unless disabled.
// - Stop resets counter, gates both clocks.
// - Recovery 4096 cycles, or 32 when short.
// - Counter held until recovery, then times it.
// - Break module idle in stop, registers kept.
// - Stop without enable raises illegal-opcode reset.
// - Break-wait flag cleared by zero write, reset.
`timescale 1ns/1ps
module sxc_ctrl #(
  parameter int NUM_IRQ = 8,
  parameter int LONG_REC = sxc_pkg::LONG_RECOVERY_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CE,
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic [NUM_IRQ-1:0] I_IRQ,
  input wire logic [NUM_IRQ-1:0] I_IRQ_EN,
  input wire logic I_CCR_MASK,
  input wire logic I_INSTR_DONE,
  input wire logic I_SWI_EXEC,
  input wire logic I_RTI_EXEC,
  input wire logic I_WAIT_EXEC,
  input wire logic I_STOP_EXEC,
  input wire logic I_STACK_DONE,
  input wire logic [15:0] I_PC,
  input wire logic I_BREAK,
  input wire logic I_RESET_SRC,
  output logic O_STACK_REQ,
  output logic O_UNSTACK_REQ,
  output logic [15:0] O_STACK_PC,
  output logic O_STACK_INDEX_HI,
  output logic O_SET_MASK,
  output logic O_CLR_MASK,
  output logic [7:0] O_VECTOR,
  output logic O_CPU_CLK_EN,
  output logic O_PERIPH_CLK_EN,
  output logic O_XTAL_CLK_EN,
  output logic O_BREAK_MODE,
  output logic O_FLAG_CLR_ALLOW,
  output logic O_BREAK_MODULE_EN,
  output logic O_WATCHDOG_RUN,
  output logic O_ILLEGAL_OP_RST,
  output logic O_INT_RESET
);

  // ==========================================================
  // Functions
  // ==========================================================
  // Lowest index has the highest priority
  function automatic logic [7:0] prio_enc(input logic [NUM_IRQ-1:0] req);
    logic [7:0] idx;
    idx = 8'h00;
    for (int k = NUM_IRQ - 1; k >= 0; k--) begin
      if (req[k]) begin
        idx = 8'(k);
      end
    end
    return idx;
  endfunction

  function automatic logic [7:0] hw_vector(input logic [7:0] idx);
    return 8'(sxc_pkg::VEC_SWI - 8'h02 - idx);
  endfunction

  // ==========================================================
  // Registers and state
  // ==========================================================
  sxc_pkg::sxc_state_t state_q;
  logic bw_q;
  logic break_clear_enable_q;
  logic [7:0] cfg_q;
  logic latched_q;
  logic [7:0] latched_idx_q;
  logic break_q;
  logic break_d;
  logic [sxc_pkg::CNT_W-1:0] cnt_q;
  logic [sxc_pkg::CNT_W-1:0] rec_len;
  logic [NUM_IRQ-1:0] pend;
  logic hw_take;

  assign pend = I_IRQ & I_IRQ_EN;
  assign hw_take = (|pend) && !I_CCR_MASK;
  assign rec_len = cfg_q[sxc_pkg::CFG_SHORT_STOP_RECOVERY_BIT] ?
    sxc_pkg::CNT_W'(sxc_pkg::SHORT_RECOVERY_CYC) : sxc_pkg::CNT_W'(LONG_REC);

  // ==========================================================
  // Register bus
  // ==========================================================
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cfg_q <= sxc_pkg::CONFIG_RST;
      break_clear_enable_q <= sxc_pkg::BFCR_RST[sxc_pkg::BREAK_CLEAR_ENABLE_BIT];
    end else if (I_CE && I_WR) begin
      if (I_ADDR == sxc_pkg::ADDR_CONFIG) begin
        cfg_q <= I_WDATA;
      end
      if (I_ADDR == sxc_pkg::ADDR_BREAK_FLAG_CTRL) begin
        break_clear_enable_q <= I_WDATA[sxc_pkg::BREAK_CLEAR_ENABLE_BIT];
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_RDATA <= 8'h00;
    end else if (I_CE) begin
      O_RDATA <= 8'h00;
      if (I_RD) begin
        case (I_ADDR)
          sxc_pkg::ADDR_BREAK_STATUS: O_RDATA <= 8'(bw_q) << sxc_pkg::BW_BIT;
          sxc_pkg::ADDR_BREAK_FLAG_CTRL: O_RDATA <= 8'(break_clear_enable_q) << sxc_pkg::BREAK_CLEAR_ENABLE_BIT;
          sxc_pkg::ADDR_CONFIG: O_RDATA <= cfg_q;
          sxc_pkg::ADDR_STATE: O_RDATA <= {3'h0, break_q, latched_q, state_q};
          sxc_pkg::ADDR_LATCHED: O_RDATA <= latched_idx_q;
          default: O_RDATA <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // Break-wait flag
  // ==========================================================
  // cleared by zero write; set wins over clear
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      bw_q <= 1'b0;
    end else if (I_CE) begin
      if (state_q == sxc_pkg::ST_WAIT && I_BREAK && !I_RESET_SRC) begin
        bw_q <= 1'b1;
      end else if (I_WR && I_ADDR == sxc_pkg::ADDR_BREAK_STATUS &&
                   !I_WDATA[sxc_pkg::BW_BIT]) begin
        bw_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Break mode and flag protection
  // ==========================================================
  // break held until return from its routine
  always_comb begin
    break_d = break_q;
    if (I_RESET_SRC) begin
      break_d = 1'b0;
    end else if (I_BREAK && state_q != sxc_pkg::ST_STOP &&
                 state_q != sxc_pkg::ST_RECOVER) begin
      break_d = 1'b1;
    end else if (I_RTI_EXEC) begin
      break_d = 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      break_q <= 1'b0;
    end else if (I_CE) begin
      break_q <= break_d;
    end
  end

  // clear allowed outside break or with enable
  // peripherals see one permission level only
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_BREAK_MODE <= 1'b0;
      O_FLAG_CLR_ALLOW <= 1'b1;
    end else if (I_CE) begin
      // Follows the entry edge, so no flag clears in the first break cycle
      O_BREAK_MODE <= break_d;
      O_FLAG_CLR_ALLOW <= !break_d || break_clear_enable_q;
    end
  end

  // ==========================================================
  // Main sequencer
  // ==========================================================
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_q <= sxc_pkg::ST_RESET;
      latched_q <= 1'b0;
      latched_idx_q <= 8'h00;
      cnt_q <= '0;
      O_STACK_REQ <= 1'b0;
      O_UNSTACK_REQ <= 1'b0;
      O_STACK_PC <= 16'h0000;
      O_STACK_INDEX_HI <= 1'b0;
      O_SET_MASK <= 1'b0;
      O_CLR_MASK <= 1'b0;
      O_VECTOR <= sxc_pkg::VEC_RESET;
      O_ILLEGAL_OP_RST <= 1'b0;
      O_INT_RESET <= 1'b1;
    end else if (I_CE) begin
      O_STACK_REQ <= 1'b0;
      O_UNSTACK_REQ <= 1'b0;
      O_SET_MASK <= 1'b0;
      O_CLR_MASK <= 1'b0;
      O_ILLEGAL_OP_RST <= 1'b0;
      // high index never part of the frame
      O_STACK_INDEX_HI <= 1'b0;
      if (latched_q && !I_CCR_MASK && state_q == sxc_pkg::ST_RUN) begin
        latched_q <= 1'b0;
      end
      if (I_RESET_SRC) begin
        state_q <= sxc_pkg::ST_RESET;
        latched_q <= 1'b0;
        O_VECTOR <= sxc_pkg::VEC_RESET;
        O_INT_RESET <= 1'b1;
      end else begin
        case (state_q)
          sxc_pkg::ST_RESET: begin
            O_INT_RESET <= 1'b0;
            state_q <= sxc_pkg::ST_RUN;
          end
          sxc_pkg::ST_RUN: begin
            if (I_BREAK) begin
              O_VECTOR <= sxc_pkg::VEC_SWI;
              O_STACK_PC <= I_PC;
              O_STACK_REQ <= 1'b1;
              O_SET_MASK <= 1'b1;
              state_q <= sxc_pkg::ST_STACK;
            end else if (I_SWI_EXEC) begin
              O_VECTOR <= sxc_pkg::VEC_SWI;
              O_STACK_PC <= I_PC;
              O_STACK_REQ <= 1'b1;
              O_SET_MASK <= 1'b1;
              state_q <= sxc_pkg::ST_STACK;
            end else if (I_RTI_EXEC) begin
              O_UNSTACK_REQ <= 1'b1;
              latched_q <= 1'b0;
            end else if (I_WAIT_EXEC) begin
              O_CLR_MASK <= 1'b1;
              state_q <= sxc_pkg::ST_WAIT;
            end else if (I_STOP_EXEC) begin
              if (!cfg_q[sxc_pkg::CFG_STOPEN_BIT]) begin
                O_ILLEGAL_OP_RST <= 1'b1;
                O_INT_RESET <= 1'b1;
                O_VECTOR <= sxc_pkg::VEC_RESET;
                state_q <= sxc_pkg::ST_RESET;
              end else begin
                O_CLR_MASK <= 1'b1;
                cnt_q <= '0;
                state_q <= sxc_pkg::ST_STOP;
              end
            end else if (I_INSTR_DONE && (latched_q || hw_take)) begin
              if (!latched_q) begin
                latched_idx_q <= prio_enc(pend);
                O_VECTOR <= hw_vector(prio_enc(pend));
              end else begin
                O_VECTOR <= hw_vector(latched_idx_q);
              end
              latched_q <= 1'b1;
              O_STACK_PC <= I_PC - 16'h0001;
              O_STACK_REQ <= 1'b1;
              O_SET_MASK <= 1'b1;
              state_q <= sxc_pkg::ST_STACK;
            end
          end
          sxc_pkg::ST_STACK: begin
            if (I_STACK_DONE) begin
              latched_q <= 1'b0;
              state_q <= sxc_pkg::ST_RUN;
            end
          end
          sxc_pkg::ST_WAIT: begin
            // wake on enabled interrupt or break
            if (I_BREAK) begin
              O_VECTOR <= sxc_pkg::VEC_SWI;
              O_STACK_PC <= I_PC;
              O_STACK_REQ <= 1'b1;
              O_SET_MASK <= 1'b1;
              state_q <= sxc_pkg::ST_STACK;
            end else if (|pend) begin
              latched_idx_q <= prio_enc(pend);
              O_VECTOR <= hw_vector(prio_enc(pend));
              latched_q <= 1'b1;
              O_STACK_PC <= I_PC - 16'h0001;
              O_STACK_REQ <= 1'b1;
              O_SET_MASK <= 1'b1;
              state_q <= sxc_pkg::ST_STACK;
            end
          end
          sxc_pkg::ST_STOP: begin
            // counter held in reset during stop
            cnt_q <= '0;
            if (|pend) begin
              latched_idx_q <= prio_enc(pend);
              state_q <= sxc_pkg::ST_RECOVER;
            end
          end
          sxc_pkg::ST_RECOVER: begin
            if (cnt_q == sxc_pkg::CNT_W'(rec_len - 1'b1)) begin
              cnt_q <= '0;
              latched_q <= 1'b1;
              O_VECTOR <= hw_vector(latched_idx_q);
              O_STACK_PC <= I_PC - 16'h0001;
              O_STACK_REQ <= 1'b1;
              O_SET_MASK <= 1'b1;
              state_q <= sxc_pkg::ST_STACK;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          default: state_q <= sxc_pkg::ST_RESET;
        endcase
      end
    end
  end

  // ==========================================================
  // Clock gating outputs
  // ==========================================================
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_CPU_CLK_EN <= 1'b0;
      O_PERIPH_CLK_EN <= 1'b0;
      O_XTAL_CLK_EN <= 1'b1;
      O_BREAK_MODULE_EN <= 1'b1;
      O_WATCHDOG_RUN <= 1'b0;
    end else if (I_CE) begin
      // CPU unclocked in wait and stop
      O_CPU_CLK_EN <= state_q == sxc_pkg::ST_RUN || state_q == sxc_pkg::ST_STACK;
      // both clock outputs off in stop
      O_PERIPH_CLK_EN <= state_q != sxc_pkg::ST_STOP && state_q != sxc_pkg::ST_RECOVER;
      O_XTAL_CLK_EN <= state_q != sxc_pkg::ST_STOP;
      O_BREAK_MODULE_EN <= state_q != sxc_pkg::ST_STOP && state_q != sxc_pkg::ST_RECOVER;
      O_WATCHDOG_RUN <= !cfg_q[sxc_pkg::CFG_WDDIS_BIT] &&
        state_q != sxc_pkg::ST_STOP && state_q != sxc_pkg::ST_RECOVER;
    end
  end

endmodule

// *** sxc_ctrl_props.sv ***
// Checker for the exception and low-power controller ports.
// Bound into every sxc_ctrl; one clock, async active-low reset.
`timescale 1ns/1ps
module sxc_ctrl_props #(
  parameter int NUM_IRQ = 8,
  parameter int LONG_REC = 4096
) (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CE,
  input wire logic [NUM_IRQ-1:0] I_IRQ,
  input wire logic [NUM_IRQ-1:0] I_IRQ_EN,
  input wire logic I_CCR_MASK,
  input wire logic I_INSTR_DONE,
  input wire logic I_SWI_EXEC,
  input wire logic I_RTI_EXEC,
  input wire logic I_WAIT_EXEC,
  input wire logic I_STOP_EXEC,
  input wire logic I_STACK_DONE,
  input wire logic [15:0] I_PC,
  input wire logic I_BREAK,
  input wire logic I_RESET_SRC,
  input wire logic O_STACK_REQ,
  input wire logic [15:0] O_STACK_PC,
  input wire logic O_STACK_INDEX_HI,
  input wire logic O_SET_MASK,
  input wire logic O_CLR_MASK,
  input wire logic [7:0] O_VECTOR,
  input wire logic O_CPU_CLK_EN,
  input wire logic O_PERIPH_CLK_EN,
  input wire logic O_XTAL_CLK_EN,
  input wire logic O_BREAK_MODE,
  input wire logic O_BREAK_MODULE_EN,
  input wire logic O_INT_RESET
);
  localparam int REC_MAX = LONG_REC + 2;
  logic busy_q;
  logic [15:0] rec_q;
  logic [NUM_IRQ-1:0] pend_w;
  logic run0_w;
  logic run_w;
  logic ev_w;
  function automatic logic [7:0] hw_vec(logic [NUM_IRQ-1:0] p);
    hw_vec = 8'h00;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (p[i]) begin
        hw_vec = 8'hFD - 8'(i);
      end
    end
  endfunction
  // ==========================================================
  // Helper state
  // ==========================================================
  assign pend_w = I_IRQ & I_IRQ_EN;
  assign run0_w = I_CE && O_CPU_CLK_EN && !busy_q && !O_STACK_REQ && !O_CLR_MASK
    && !O_INT_RESET && !I_RESET_SRC;
  assign run_w = run0_w && !I_BREAK;
  assign ev_w = I_SWI_EXEC || I_RTI_EXEC || I_WAIT_EXEC || I_STOP_EXEC;
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      busy_q <= 1'h0;
    end else if (O_STACK_REQ) begin
      busy_q <= 1'h1;
    end else if (I_STACK_DONE) begin
      busy_q <= 1'h0;
    end
  end
  // Length of the current recovery stretch
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rec_q <= 16'h0000;
    end else if (O_XTAL_CLK_EN && !O_PERIPH_CLK_EN && !O_INT_RESET) begin
      rec_q <= rec_q + 16'h0001;
    end else begin
      rec_q <= 16'h0000;
    end
  end
  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  index_never_a: assert property (O_STACK_INDEX_HI == 1'h0)
    else $error("high index stacked");
  swi_entry_a: assert property (run_w && I_SWI_EXEC |=> O_STACK_REQ && O_SET_MASK
    && O_VECTOR == sxc_pkg::VEC_SWI && O_STACK_PC == $past(I_PC))
    else $error("software entry wrong");
  break_entry_a: assert property (run0_w && I_BREAK |=> O_STACK_REQ && O_BREAK_MODE
    && O_VECTOR == sxc_pkg::VEC_SWI)
    else $error("break entry wrong");
  reset_wins_a: assert property (I_CE && I_RESET_SRC |=> O_INT_RESET && !O_STACK_REQ)
    else $error("reset did not win");
  mask_blocks_a: assert property (run_w && !ev_w && I_INSTR_DONE && I_CCR_MASK
    |=> !O_STACK_REQ)
    else $error("masked request taken");
  hw_entry_a: assert property (run_w && !ev_w && I_INSTR_DONE && !I_CCR_MASK && |pend_w
    |=> O_STACK_REQ && O_VECTOR == hw_vec($past(pend_w))
    && O_STACK_PC == $past(I_PC) - 16'h0001)
    else $error("hardware entry wrong");
  wait_entry_a: assert property (run_w && I_WAIT_EXEC && !I_SWI_EXEC && !I_RTI_EXEC
    |=> O_CLR_MASK ##1 !O_CPU_CLK_EN && O_PERIPH_CLK_EN)
    else $error("wait entry wrong");
  stop_gated_a: assert property (!O_XTAL_CLK_EN |-> !O_CPU_CLK_EN && !O_PERIPH_CLK_EN
    && !O_BREAK_MODULE_EN)
    else $error("clock live in stop");
  recovery_len_a: assert property (rec_q <= REC_MAX)
    else $error("recovery too long");
endmodule
bind sxc_ctrl sxc_ctrl_props #(.NUM_IRQ(NUM_IRQ), .LONG_REC(LONG_REC)) u_sxc_ctrl_props (.*);

// *** sxc_cpu_model.sv ***
// CPU core stand-in: answers each stacking request with a done pulse.
// The bench sets the delay, so answers come promptly or slowly.
`timescale 1ns/1ps
module sxc_cpu_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_stack_req,
  input wire logic [3:0] i_delay,
  output logic o_stack_done
);
  logic [4:0] cnt_q;
  // ==========================================================
  // Stacking handshake
  // ==========================================================
  // frame push time
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= 5'h00;
      o_stack_done <= 1'h0;
    end else begin
      o_stack_done <= (cnt_q == 5'h01);
      if (i_stack_req) begin
        cnt_q <= {1'h0, i_delay} + 5'h01;
      end else if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end
endmodule

// *** sxc_ctrl_tb.sv ***
// Self-checking bench for sxc_ctrl with a CPU stand-in.
// Assumes LONG_REC may be shortened; one 250 MHz clock.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module sxc_ctrl_tb;
  localparam int LR = 64;
  logic I_CLK = 1'h0;
  logic I_RESET_N = 1'h0;
  logic I_CE = 1'h1;
  logic I_WR = 1'h0, I_RD = 1'h0, I_CCR_MASK = 1'h0;
  logic I_INSTR_DONE = 1'h0, I_SWI_EXEC = 1'h0, I_RTI_EXEC = 1'h0, I_WAIT_EXEC = 1'h0;
  logic I_STOP_EXEC = 1'h0, I_BREAK = 1'h0, I_RESET_SRC = 1'h0;
  logic I_STACK_DONE;
  logic [3:0] I_ADDR = 4'h0;
  logic [3:0] dly = 4'h4;
  logic [7:0] I_WDATA = 8'h00, I_IRQ = 8'h00, I_IRQ_EN = 8'h00;
  logic [15:0] I_PC = 16'h0000;
  logic [7:0] O_RDATA, O_VECTOR;
  logic [15:0] O_STACK_PC;
  logic O_STACK_REQ, O_UNSTACK_REQ, O_STACK_INDEX_HI, O_SET_MASK, O_CLR_MASK, O_CPU_CLK_EN;
  logic O_PERIPH_CLK_EN, O_XTAL_CLK_EN, O_BREAK_MODE, O_FLAG_CLR_ALLOW, O_BREAK_MODULE_EN;
  logic O_WATCHDOG_RUN, O_ILLEGAL_OP_RST, O_INT_RESET;
  int err_total = 0, tests_run = 0, seed = 11, n;
  sxc_ctrl #(.NUM_IRQ(8), .LONG_REC(LR)) u_sxc_ctrl (.*);
  sxc_cpu_model u_sxc_cpu_model (.i_clk(I_CLK), .i_reset_n(I_RESET_N),
    .i_stack_req(O_STACK_REQ), .i_delay(dly), .o_stack_done(I_STACK_DONE));
  initial forever #2 I_CLK = ~I_CLK;
  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic wrap_up;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic do_reset;
    I_RESET_N <= 1'h0;
    repeat (8) @(posedge I_CLK);
    `CHK({O_INT_RESET, O_VECTOR}, {1'h1, sxc_pkg::VEC_RESET})
    I_RESET_N <= 1'h1;
    repeat (3) @(posedge I_CLK);
  endtask
  // Bits: done, soft, return, wait, stop, break, reset source
  task automatic ev(logic [6:0] p);
    @(posedge I_CLK);
    {I_INSTR_DONE, I_SWI_EXEC, I_RTI_EXEC, I_WAIT_EXEC, I_STOP_EXEC, I_BREAK, I_RESET_SRC} <= p;
    @(posedge I_CLK);
    {I_INSTR_DONE, I_SWI_EXEC, I_RTI_EXEC, I_WAIT_EXEC, I_STOP_EXEC, I_BREAK, I_RESET_SRC} <= 7'h00;
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'h1;
    @(posedge I_CLK);
    I_WR <= 1'h0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_RD <= 1'h1;
    @(posedge I_CLK);
    I_RD <= 1'h0;
    #1 `CHK(O_RDATA, e)
  endtask
  task automatic wait_done;
    for (n = 0; n < 60; n++) begin
      @(posedge I_CLK);
      if (I_STACK_DONE === 1'h1) return;
    end
    err_total++;
    wrap_up;
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    logic [7:0] p;
    logic [7:0] e;
    logic m;
    logic [15:0] pc;
    int idx;
    do_reset;
    rd(sxc_pkg::ADDR_CONFIG, sxc_pkg::CONFIG_RST);
    rd(sxc_pkg::ADDR_BREAK_FLAG_CTRL, sxc_pkg::BFCR_RST);
    rd(4'hF, 8'h00);
    @(posedge I_CLK);
    I_CE <= 1'h0;
    ev(7'h20);
    #1 `CHK(O_STACK_REQ, 1'h0)
    @(posedge I_CLK);
    I_CE <= 1'h1;
    repeat (30) begin
      p = 8'($random(seed));
      e = 8'($random(seed)) | 8'h11;
      m = ($random(seed) % 4) == 0;
      pc = 16'($random(seed));
      idx = 8;
      for (int i = 7; i >= 0; i--) if (p[i] && e[i]) idx = i;
      @(posedge I_CLK);
      I_IRQ <= p;
      I_IRQ_EN <= e;
      I_CCR_MASK <= m;
      I_PC <= pc;
      dly <= 4'($random(seed)) | 4'h4;
      ev(7'h40);
      I_IRQ <= 8'hFF;
      #1;
      if (m || idx == 8) begin
        `CHK(O_STACK_REQ, 1'h0)
      end else begin
        `CHK({O_STACK_REQ, O_SET_MASK}, 2'h3)
        `CHK(O_VECTOR, 8'hFD - 8'(idx))
        `CHK(O_STACK_PC, pc - 16'h0001)
        rd(sxc_pkg::ADDR_LATCHED, 8'(idx));
        ev(7'h40);
        `CHK(O_VECTOR, 8'hFD - 8'(idx))
        wait_done;
        I_IRQ <= 8'h00;
        ev(7'h10);
        #1 `CHK(O_UNSTACK_REQ, 1'h1)
      end
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge I_CLK);
      I_IRQ <= 8'h00;
      I_CCR_MASK <= 1'h1;
      I_PC <= 16'hA5A4;
      ev(k ? 7'h02 : 7'h20);
      #1 `CHK(O_VECTOR, sxc_pkg::VEC_SWI)
      `CHK(O_STACK_PC, 16'hA5A4)
      `CHK({O_BREAK_MODE, O_FLAG_CLR_ALLOW}, {1'(k), 1'(!k)})
      wr(sxc_pkg::ADDR_BREAK_FLAG_CTRL, 8'h80);
      @(posedge I_CLK);
      #1 `CHK(O_FLAG_CLR_ALLOW, 1'h1)
      wait_done;
      ev(7'h10);
      do_reset;
    end
    @(posedge I_CLK);
    I_IRQ_EN <= 8'hFF;
    for (int k = 0; k < 2; k++) begin
      ev(7'h08);
      I_CCR_MASK <= 1'h0;
      #1 `CHK(O_CLR_MASK, 1'h1)
      @(posedge I_CLK);
      #1 `CHK({O_CPU_CLK_EN, O_PERIPH_CLK_EN, O_WATCHDOG_RUN}, 3'h3)
      if (k == 0) begin
        @(posedge I_CLK);
        I_IRQ <= 8'h08;
        @(posedge I_CLK);
        I_IRQ <= 8'h00;
      end else ev(7'h02);
      #1 `CHK({O_STACK_REQ, O_VECTOR}, {1'h1, k ? sxc_pkg::VEC_SWI : 8'hFA})
      wait_done;
      ev(7'h10);
    end
    rd(sxc_pkg::ADDR_BREAK_STATUS, 8'h02);
    wr(sxc_pkg::ADDR_BREAK_STATUS, 8'h00);
    rd(sxc_pkg::ADDR_BREAK_STATUS, 8'h00);
    wr(sxc_pkg::ADDR_CONFIG, 8'h04);
    @(posedge I_CLK);
    #1 `CHK(O_WATCHDOG_RUN, 1'h0)
    for (int k = 0; k < 2; k++) begin
      do_reset;
      wr(sxc_pkg::ADDR_CONFIG, {6'h00, 1'h1, 1'(k)});
      wr(sxc_pkg::ADDR_BREAK_FLAG_CTRL, 8'h80);
      ev(7'h04);
      #1 `CHK(O_CLR_MASK, 1'h1)
      @(posedge I_CLK);
      #1 `CHK(O_XTAL_CLK_EN, 1'h0)
      @(posedge I_CLK);
      I_IRQ <= 8'h01;
      @(posedge I_CLK);
      I_IRQ <= 8'h00;
      for (n = 0; n < 5000 && O_STACK_REQ !== 1'h1; n++) @(posedge I_CLK) #1;
      idx = k ? sxc_pkg::SHORT_RECOVERY_CYC : LR;
      `CHK(n >= idx && n <= idx + 3, 1'h1)
      `CHK(O_VECTOR, 8'hFD)
      wait_done;
      rd(sxc_pkg::ADDR_BREAK_FLAG_CTRL, 8'h80);
    end
    do_reset;
    ev(7'h04);
    #1 `CHK(O_ILLEGAL_OP_RST, 1'h1)
    do_reset;
    @(posedge I_CLK);
    I_IRQ <= 8'h01;
    ev(7'h41);
    #1 `CHK({O_INT_RESET, O_STACK_REQ}, 2'h2)
    wrap_up;
  end
endmodule
